// ===== rtl/twi_port_pkg.sv
// constants and types shared by the two-wire register port
package twi_port_pkg;

    // ==========================================
    // strap sensing: bit 1 = above upper threshold, bit 0 = above lower threshold
    localparam logic [1:0] SENSE_LOW   = 2'h0;
    localparam logic [1:0] SENSE_HIGH  = 2'h3;
    localparam logic [1:0] LVL_LOW     = 2'h0;
    localparam logic [1:0] LVL_OPEN    = 2'h1;
    localparam logic [1:0] LVL_HIGH    = 2'h2;
    localparam logic [3:0] ADDR_MSBS   = 4'hb;
    localparam logic [2:0] STRAP_WAIT  = 3'h4;

    // ==========================================
    // byte framing and register space
    localparam logic [3:0]  BYTE_BITS  = 4'h8;
    localparam int          REG_DEPTH  = 256;
    localparam int          REG_AW     = 8;
    localparam logic [15:0] ADDR_RST   = 16'h0000;
    localparam logic [7:0]  DATA_RST   = 8'h00;

    // ==========================================
    // types
    typedef enum logic [2:0] {
        ST_IDLE,
        ST_ADDR,
        ST_REGH,
        ST_REGL,
        ST_WDATA,
        ST_RDATA
    } link_state_t;

    typedef struct packed {
        logic        we;
        logic [15:0] addr;
        logic [7:0]  wdata;
    } reg_req_t;

    typedef struct packed {
        logic        valid;
        logic [15:0] addr;
        logic [7:0]  data;
    } cfg_wr_t;

    // ==========================================
    // helpers
    function automatic logic [1:0] strap_level(input logic [1:0] sense);
        strap_level = (sense == SENSE_LOW)  ? LVL_LOW :
                      (sense == SENSE_HIGH) ? LVL_HIGH : LVL_OPEN;
    endfunction

    function automatic logic [2:0] addr_lsbs(input logic [1:0] up, input logic [1:0] lo);
        addr_lsbs = ({1'b0, up} << 1) + {1'b0, up} + {1'b0, lo};
    endfunction

endpackage

// ===== rtl/sync_level.sv
// two flip-flop level synchroniser
`timescale 1ns/100ps
module sync_level #(
    parameter int           W    = 1,
    parameter logic [W-1:0] INIT = '0
) (
    input  wire logic         clk,
    input  wire logic         rst,
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);
    logic [W-1:0] meta;

    always_ff @(posedge clk) begin
        if (rst) begin
            meta <= INIT;
            q    <= INIT;
        end else begin
            meta <= d;
            q    <= meta;
        end
    end
endmodule

// ===== rtl/two_wire_register_port.sv
// two-wire slave register port: link engine on link_clk, register store on clk_sys
`timescale 1ns/100ps
module two_wire_register_port
    import twi_port_pkg::*;
(
    input  wire logic       clk_sys,
    input  wire logic       rst,
    input  wire logic       link_clk,
    input  wire logic       scl,
    input  wire logic       sda_in,
    output logic            sda_out,
    output logic            sda_oe,
    input  wire logic [1:0] port_strap_upper,
    input  wire logic [1:0] port_strap_lower,
    input  wire logic       chip_sleep_n,
    output logic            spi_enable,
    output logic [6:0]      slave_addr,
    output logic            sleep_active,
    output cfg_wr_t         cfg_wr
);

    // ==========================================
    // system domain: strap capture
    logic [3:0] strap_s;
    logic       sleep_n_s;
    logic [2:0] strap_cnt;
    logic       strap_done;

    sync_level #(.W(5), .INIT(5'h1f)) u_sync_sys (
        .clk (clk_sys),
        .rst (rst),
        .d   ({port_strap_upper, port_strap_lower, chip_sleep_n}),
        .q   ({strap_s, sleep_n_s})
    );

    wire logic [1:0] up_lvl    = strap_level(strap_s[3:2]);
    wire logic [1:0] lo_lvl    = strap_level(strap_s[1:0]);
    wire logic       take_strap = !strap_done && (strap_cnt == STRAP_WAIT);

    // straps are caught once after reset so a drifting open pin cannot move the address
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            strap_cnt  <= 3'h0;
            strap_done <= 1'b0;
            spi_enable <= 1'b0;
            slave_addr <= {ADDR_MSBS, 3'h0};
        end else begin
            if (!strap_done)
                strap_cnt <= strap_cnt + 3'h1;
            if (take_strap) begin
                strap_done <= 1'b1;
                spi_enable <= (up_lvl == LVL_HIGH) && (lo_lvl == LVL_HIGH);
                slave_addr <= {ADDR_MSBS, addr_lsbs(up_lvl, lo_lvl)};
            end
        end
    end

    // ==========================================
    // system domain: register store behind the request handshake
    logic [7:0] regs [REG_DEPTH];
    reg_req_t   req;
    logic       req_tog;
    logic       req_tog_s;
    logic       req_seen;
    logic       ack_tog;
    logic [7:0] rd_data;

    sync_level #(.W(1), .INIT(1'b0)) u_sync_req (
        .clk (clk_sys),
        .rst (rst),
        .d   (req_tog),
        .q   (req_tog_s)
    );

    wire logic req_new  = req_tog_s != req_seen;
    wire logic in_range = req.addr < 16'(REG_DEPTH);
    wire logic [REG_AW-1:0] ridx = req.addr[REG_AW-1:0];

    // sleep is only reported; it gates neither the store nor the port
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            req_seen     <= 1'b0;
            ack_tog      <= 1'b0;
            rd_data      <= DATA_RST;
            cfg_wr       <= '0;
            sleep_active <= 1'b0;
            for (int i = 0; i < REG_DEPTH; i++)
                regs[i] <= DATA_RST;
        end else begin
            sleep_active <= !sleep_n_s;
            cfg_wr.valid <= 1'b0;
            if (req_new) begin
                req_seen <= req_tog_s;
                ack_tog  <= !ack_tog;
                rd_data  <= in_range ? regs[ridx] : DATA_RST;
                if (req.we) begin
                    cfg_wr <= '{valid: 1'b1, addr: req.addr, data: req.wdata};
                    if (in_range)
                        regs[ridx] <= req.wdata;
                end
            end
        end
    end

    // ==========================================
    // link domain: resets, pin and configuration synchronisers
    logic       lrst;
    logic       scl_s;
    logic       sda_s;
    logic       scl_q;
    logic       sda_q;
    logic       spi_l;
    logic [6:0] addr_l;
    logic       ack_tog_s;

    sync_level #(.W(1), .INIT(1'b1)) u_sync_rst (
        .clk (link_clk),
        .rst (1'b0),
        .d   (rst),
        .q   (lrst)
    );

    // sampling at link_clk keeps many samples per bit at either bus rate
    sync_level #(.W(2), .INIT(2'h3)) u_sync_pins (
        .clk (link_clk),
        .rst (lrst),
        .d   ({scl, sda_in}),
        .q   ({scl_s, sda_s})
    );

    // previous sample for edge and condition detection; resets to the idle bus level so no false edge follows
    always_ff @(posedge link_clk) begin
        if (lrst) begin
            scl_q <= 1'b1;
            sda_q <= 1'b1;
        end else begin
            scl_q <= scl_s;
            sda_q <= sda_s;
        end
    end

    // address and mode are quasi-static after strap capture
    sync_level #(.W(9), .INIT(9'h0b0)) u_sync_cfg (
        .clk (link_clk),
        .rst (lrst),
        .d   ({spi_enable, slave_addr, ack_tog}),
        .q   ({spi_l, addr_l, ack_tog_s})
    );

    // ==========================================
    // link domain: bus events
    link_state_t state;
    logic [3:0]  cnt;
    logic        in_ack;
    logic        rw;
    logic        master_nack;
    logic [7:0]  shift;
    logic [7:0]  tx;
    logic [7:0]  addr_hi;
    logic [15:0] cur_addr;
    logic        ack_seen;
    logic [7:0]  rd_buf;

    wire logic scl_rise  = scl_s && !scl_q;
    wire logic scl_fall  = !scl_s && scl_q;
    wire logic start_det = scl_s && scl_q && sda_q && !sda_s;
    wire logic stop_det  = scl_s && scl_q && !sda_q && sda_s;
    wire logic active    = state != ST_IDLE;
    wire logic byte_done = active && scl_fall && !in_ack && (cnt == BYTE_BITS);
    wire logic ack_done  = active && scl_fall && in_ack;
    wire logic bit_fall  = active && scl_fall && !in_ack && (cnt != 4'h0) && (cnt < BYTE_BITS);
    wire logic addr_hit  = (shift[7:1] == addr_l) && !spi_l;
    wire logic load_tx   = ack_done && ((state == ST_ADDR && rw) || (state == ST_RDATA && !master_nack));
    wire logic rd_first  = byte_done && state == ST_ADDR && addr_hit && shift[0];
    wire logic rd_issue  = rd_first || load_tx;
    wire logic wr_issue  = byte_done && state == ST_WDATA;
    wire logic rd_nack   = ack_done && state == ST_RDATA && master_nack;
    wire logic regl_done = byte_done && state == ST_REGL;

    // ==========================================
    // link domain: read-data return path
    always_ff @(posedge link_clk) begin
        if (lrst) begin
            ack_seen <= 1'b0;
            rd_buf   <= DATA_RST;
        end else if (ack_tog_s != ack_seen) begin
            ack_seen <= ack_tog_s;
            rd_buf   <= rd_data;
        end
    end

    // ==========================================
    // link domain: request launch; fields settle before the toggle is seen
    always_ff @(posedge link_clk) begin
        if (lrst) begin
            req     <= '0;
            req_tog <= 1'b0;
        end else if (wr_issue) begin
            req     <= '{we: 1'b1, addr: cur_addr, wdata: shift};
            req_tog <= !req_tog;
        end else if (rd_issue) begin
            // after a load, fetch ahead so the next byte is ready at the ack
            req     <= '{we: 1'b0, addr: rd_first ? cur_addr : cur_addr + 16'h1, wdata: DATA_RST};
            req_tog <= !req_tog;
        end
    end

    // ==========================================
    // link domain: byte engine; only sda is ever driven, scl is input only
    always_ff @(posedge link_clk) begin
        if (lrst) begin
            state       <= ST_IDLE;
            cnt         <= 4'h0;
            in_ack      <= 1'b0;
            rw          <= 1'b0;
            master_nack <= 1'b0;
            shift       <= DATA_RST;
            tx          <= DATA_RST;
            addr_hi     <= DATA_RST;
            cur_addr    <= ADDR_RST;
            sda_oe      <= 1'b0;
            sda_out     <= 1'b0;
        end else if (start_det && !spi_l) begin
            state  <= ST_ADDR;
            cnt    <= 4'h0;
            in_ack <= 1'b0;
            sda_oe <= 1'b0;
        end else if (stop_det) begin
            state  <= ST_IDLE;
            cnt    <= 4'h0;
            in_ack <= 1'b0;
            sda_oe <= 1'b0;
        end else if (active) begin
            if (scl_rise && !in_ack && cnt < BYTE_BITS) begin
                cnt   <= cnt + 4'h1;
                shift <= {shift[6:0], sda_s};
            end
            if (scl_rise && in_ack)
                master_nack <= sda_s;
            if (bit_fall && state == ST_RDATA) begin
                tx     <= {tx[6:0], 1'b0};
                sda_oe <= !tx[6];
            end
            if (byte_done) begin
                in_ack <= 1'b1;
                case (state)
                    ST_ADDR: begin
                        rw     <= shift[0];
                        sda_oe <= addr_hit;
                        if (!addr_hit)
                            state <= ST_IDLE;
                    end
                    ST_REGH: begin
                        addr_hi <= shift;
                        sda_oe  <= 1'b1;
                    end
                    ST_REGL: begin
                        cur_addr <= {addr_hi, shift};
                        sda_oe   <= 1'b1;
                    end
                    ST_WDATA: begin
                        cur_addr <= cur_addr + 16'h1;
                        sda_oe   <= 1'b1;
                    end
                    ST_RDATA: sda_oe <= 1'b0;
                    default: sda_oe <= 1'b0;
                endcase
            end
            if (ack_done) begin
                in_ack <= 1'b0;
                cnt    <= 4'h0;
                sda_oe <= 1'b0;
                case (state)
                    ST_ADDR:  state <= rw ? ST_RDATA : ST_REGH;
                    ST_REGH:  state <= ST_REGL;
                    ST_REGL:  state <= ST_WDATA;
                    ST_WDATA: state <= ST_WDATA;
                    ST_RDATA: state <= master_nack ? ST_IDLE : ST_RDATA;
                    default:  state <= ST_IDLE;
                endcase
                if (load_tx) begin
                    tx       <= rd_buf;
                    sda_oe   <= !rd_buf[7];
                    cur_addr <= cur_addr + 16'h1;
                end
            end
        end
    end

    // ==========================================
    // checks
    spi_select_a: assert property (
        @(posedge clk_sys) disable iff (rst)
        take_strap |=> spi_enable == (up_lvl == LVL_HIGH && lo_lvl == LVL_HIGH))
        else $error("port select does not follow straps");

    addr_msbs_a: assert property (
        @(posedge clk_sys) disable iff (rst)
        take_strap && !(up_lvl == LVL_HIGH && lo_lvl == LVL_HIGH)
            |=> slave_addr == {ADDR_MSBS, {1'b0, up_lvl} * 3'h3 + {1'b0, lo_lvl}})
        else $error("slave address does not follow straps");

    strap_hold_a: assert property (
        @(posedge clk_sys) disable iff (rst)
        strap_done && $past(strap_done) |-> $stable(slave_addr) && $stable(spi_enable))
        else $error("strap decode moved after capture");

    sda_high_a: assert property (
        @(posedge link_clk) disable iff (lrst)
        scl_s && $past(scl_s) && !$past(start_det) && !$past(stop_det) |-> $stable(sda_oe))
        else $error("sda changed while clock high");

    start_seen_a: assert property (
        @(posedge link_clk) disable iff (lrst)
        start_det && !spi_l |=> state == ST_ADDR && cnt == 4'h0 && !sda_oe)
        else $error("start not taken");

    stop_seen_a: assert property (
        @(posedge link_clk) disable iff (lrst)
        stop_det |=> state == ST_IDLE && !sda_oe ##1 !sda_oe)
        else $error("stop did not release bus");

    addr_miss_a: assert property (
        @(posedge link_clk) disable iff (lrst)
        byte_done && state == ST_ADDR && !addr_hit |=> state == ST_IDLE && !sda_oe)
        else $error("foreign address acknowledged");

    reg_addr_a: assert property (
        @(posedge link_clk) disable iff (lrst)
        regl_done |=> cur_addr == {$past(addr_hi), $past(shift)})
        else $error("register address not loaded");

    addr_step_a: assert property (
        @(posedge link_clk) disable iff (lrst)
        wr_issue |=> cur_addr == $past(cur_addr) + 16'h1 && req.we && req.addr == $past(cur_addr))
        else $error("address did not advance on write");

    read_nack_a: assert property (
        @(posedge link_clk) disable iff (lrst)
        rd_nack |=> state == ST_IDLE && !sda_oe)
        else $error("transmit continued after no-acknowledge");

endmodule

// ===== testbench/twi_master_model.sv
// bus master model: drives the serial clock and pulls the data line low
`timescale 1ns/100ps
module twi_master_model (
    output logic      scl,
    output logic      sda_pull,
    input  wire logic sda
);
    int t_low  = 1300;
    int t_high = 1200;

    initial begin
        scl      = 1'h1;
        sda_pull = 1'h0;
    end

    // ==========================================
    // bit level
    // data moves late in the low phase so the slave's own turn-around has landed first
    task automatic clock_bit(input logic bv, output logic seen);
        #(t_low - 300) sda_pull = !bv;
        #300 scl = 1'h1;
        #(t_high) seen = sda;
        scl = 1'h0;
    endtask

    task automatic start_cond();
        #(t_low - 300) sda_pull = 1'h0;
        #300 scl = 1'h1;
        #(t_high) sda_pull = 1'h1;
        #(t_high) scl = 1'h0;
    endtask

    // the clock is left high afterwards: an idle bus, not a running clock
    task automatic stop_cond();
        #(t_low - 300) sda_pull = 1'h1;
        #300 scl = 1'h1;
        #(t_high) sda_pull = 1'h0;
        #(t_high);
    endtask

    // ==========================================
    // byte level
    task automatic send_bits(input logic [7:0] v, input int n, output logic ack);
        logic seen;
        seen = 1'h1;
        for (int i = 7; i > 7 - n; i--) begin
            clock_bit(v[i], seen);
        end
        if (n == 8) begin
            clock_bit(1'h1, seen);
        end
        ack = !seen;
    endtask

    task automatic recv_byte(input logic last, output logic [7:0] v);
        logic seen;
        for (int i = 7; i >= 0; i--) begin
            clock_bit(1'h1, seen);
            v[i] = seen;
        end
        clock_bit(last, seen);
    endtask
endmodule

// ===== testbench/two_wire_register_port_bench.sv
// self-checking bench for the two-wire register port
`timescale 1ns/100ps
module two_wire_register_port_bench
    import twi_port_pkg::*;
;
    typedef struct packed {
        logic [1:0] up;
        logic [1:0] lo;
        logic [6:0] addr;
        logic       spi;
    } row_t;

    logic       clk_sys = 1'h0;
    logic       link_clk = 1'h0;
    logic       rst = 1'h1;
    logic [1:0] port_strap_upper = 2'h0;
    logic [1:0] port_strap_lower = 2'h0;
    logic       chip_sleep_n = 1'h1;
    logic       scl, sda_pull, sda_out, sda_oe, spi_enable, sleep_active, a;
    logic [6:0] slave_addr;
    logic [7:0] b;
    cfg_wr_t    cfg_wr;
    cfg_wr_t    cfgq[$];
    int         n_errors = 0;
    int         n_tests = 0;
    wire logic  sda = (sda_oe ? sda_out : 1'h1) && !sda_pull;
    row_t       rows[10] = '{
        '{2'h2, 2'h2, 7'h5c, 1'h0}, '{2'h0, 2'h1, 7'h59, 1'h0}, '{2'h0, 2'h3, 7'h5a, 1'h0},
        '{2'h1, 2'h0, 7'h5b, 1'h0}, '{2'h1, 2'h1, 7'h5c, 1'h0}, '{2'h1, 2'h3, 7'h5d, 1'h0},
        '{2'h3, 2'h0, 7'h5e, 1'h0}, '{2'h3, 2'h1, 7'h5f, 1'h0}, '{2'h3, 2'h3, 7'h58, 1'h1},
        '{2'h0, 2'h0, 7'h58, 1'h0}};

    always #20 clk_sys = ~clk_sys;
    initial begin
        #37;
        forever #80 link_clk = ~link_clk;
    end

    two_wire_register_port dut (
        .clk_sys(clk_sys), .rst(rst), .link_clk(link_clk), .scl(scl), .sda_in(sda),
        .sda_out(sda_out), .sda_oe(sda_oe), .port_strap_upper(port_strap_upper),
        .port_strap_lower(port_strap_lower), .chip_sleep_n(chip_sleep_n), .spi_enable(spi_enable),
        .slave_addr(slave_addr), .sleep_active(sleep_active), .cfg_wr(cfg_wr)
    );
    twi_master_model master (.scl(scl), .sda_pull(sda_pull), .sda(sda));

    always @(posedge clk_sys) begin
        if (cfg_wr.valid === 1'h1) begin
            cfgq.push_back(cfg_wr);
        end
    end

    // the slave may only turn the data line around while the clock is low
    always @(sda_oe) begin
        if (scl === 1'h1 && rst === 1'h0) begin
            check(1'h1, 1'h0);
        end
    end

    // ==========================================
    // checking and bus helpers
    task automatic check(input logic [24:0] seen, input logic [24:0] exp);
        n_tests++;
        if (seen !== exp) begin
            n_errors++;
            $display("BAD at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic give_verdict();
        $display("mismatches %0d of %0d checks", n_errors, n_tests);
        if (n_errors == 0 && n_tests > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    task automatic put(input logic [7:0] v, input logic exp_ack);
        master.send_bits(v, 8, a);
        check(a, exp_ack);
    endtask

    task automatic get(input logic [7:0] exp, input logic last);
        master.recv_byte(last, b);
        check(b, exp);
    endtask

    // leaves the bus open so the caller may stop, restart or carry on with data
    task automatic set_addr(input logic [15:0] ra);
        master.start_cond();
        put(8'hb0, 1'h1);
        put(ra[15:8], 1'h1);
        put(ra[7:0], 1'h1);
    endtask

    task automatic check_cfg(input logic [15:0] ra, input logic [7:0] d);
        int k;
        k = 0;
        while (cfgq.size() == 0 && k < 400) begin
            @(posedge clk_sys);
            k++;
        end
        if (cfgq.size() == 0) begin
            n_errors++;
            $display("BAD at %0t: no register write seen", $time);
            give_verdict();
        end else begin
            check(cfgq.pop_front(), {1'h1, ra, d});
        end
    endtask

    // ==========================================
    // main sequence
    initial begin
        repeat (16) @(posedge clk_sys);
        foreach (rows[i]) begin
            @(posedge clk_sys);
            rst              <= 1'h1;
            port_strap_upper <= rows[i].up;
            port_strap_lower <= rows[i].lo;
            repeat (20) @(posedge clk_sys);
            rst <= 1'h0;
            repeat (100) @(posedge clk_sys);
            check(spi_enable, rows[i].spi);
            if (!rows[i].spi) begin
                check(slave_addr, rows[i].addr);
            end
            master.start_cond();
            put({rows[i].addr, 1'h0}, !rows[i].spi);
            master.stop_cond();
        end
        set_addr(16'h0012);
        put(8'h5a, 1'h1);
        put(8'ha5, 1'h1);
        put(8'h3c, 1'h1);
        master.stop_cond();
        check_cfg(16'h0012, 8'h5a);
        check_cfg(16'h0013, 8'ha5);
        check_cfg(16'h0014, 8'h3c);
        set_addr(16'h0012);
        master.stop_cond();
        master.start_cond();
        put(8'hb1, 1'h1);
        get(8'h5a, 1'h0);
        get(8'ha5, 1'h1);
        #1500;
        check(sda_oe, 1'h0);
        check(sda_out, 1'h0);
        master.stop_cond();
        // standard rate with a repeated start; the read resumes where the last one stopped
        master.t_low  = 5000;
        master.t_high = 5000;
        master.start_cond();
        put(8'hb1, 1'h1);
        get(8'h3c, 1'h1);
        set_addr(16'h0013);
        master.start_cond();
        put(8'hb1, 1'h1);
        get(8'ha5, 1'h1);
        master.stop_cond();
        master.t_low  = 1300;
        master.t_high = 1200;
        master.start_cond();
        put(8'hb2, 1'h0);
        put(8'h00, 1'h0);
        master.stop_cond();
        set_addr(16'h0030);
        master.send_bits(8'hff, 4, a);
        master.stop_cond();
        set_addr(16'h0031);
        master.send_bits(8'hf0, 6, a);
        master.start_cond();
        put(8'hb1, 1'h1);
        get(8'h00, 1'h1);
        master.stop_cond();
        check(25'(cfgq.size()), 25'h0);
        @(posedge clk_sys);
        chip_sleep_n <= 1'h0;
        repeat (20) @(posedge clk_sys);
        check(sleep_active, 1'h1);
        set_addr(16'hffff);
        put(8'h11, 1'h1);
        put(8'h77, 1'h1);
        master.stop_cond();
        check_cfg(16'hffff, 8'h11);
        check_cfg(16'h0000, 8'h77);
        @(posedge clk_sys);
        chip_sleep_n <= 1'h1;
        repeat (20) @(posedge clk_sys);
        check(sleep_active, 1'h0);
        set_addr(16'h0000);
        master.start_cond();
        put(8'hb1, 1'h1);
        get(8'h77, 1'h1);
        master.stop_cond();
        give_verdict();
    end
endmodule
